//--- core/usdp_fifo.sv
module usdp_fifo
    import usdp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = USDP_FIFO_DEPTH
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             flush,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] head,
    output logic                  empty,
    output logic                  full
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("usdp_fifo depth must be at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    wp_nxt;
    logic [AW-1:0]    rp_r;
    logic [AW-1:0]    rp_nxt;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             do_push;
    logic             do_pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction : bump

    assign empty   = (cnt_r == '0);
    assign full    = (cnt_r == (AW+1)'(DEPTH));
    assign head    = mem[rp_r];
    // full fifo drops the push, contents untouched
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;

    always_comb begin
        wp_nxt  = do_push ? bump(wp_r) : wp_r;
        rp_nxt  = do_pop ? bump(rp_r) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        if (flush) begin
            wp_nxt  = '0;
            rp_nxt  = '0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge hclk) begin
        if (do_push && !flush) begin
            mem[wp_r] <= push_data;
        end
    end
endmodule : usdp_fifo

//--- core/usdp_hold.sv
module usdp_hold
    import usdp_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       load,
    input  wire logic [7:0] load_data,
    input  wire logic       take,
    output usdp_byte_t      slot
);
    usdp_byte_t slot_r;
    usdp_byte_t slot_nxt;

    assign slot = slot_r;

    // a load overwrites an unconsumed byte; load wins over take
    always_comb begin
        slot_nxt = slot_r;
        if (take) begin
            slot_nxt.valid = 1'b0;
        end
        if (load) begin
            slot_nxt.valid = 1'b1;
            slot_nxt.data  = load_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slot_r <= '{valid: 1'b0, data: USDP_DATA_RESET};
        end else begin
            slot_r <= slot_nxt;
        end
    end
endmodule : usdp_hold

//--- core/usdp_pkg.sv
// Contract
// - every shadow word reads the receive buffer and writes the transmit holding register; with fifos on the write goes to the transmit fifo instead.
// - with fifos off the low byte of a read is the most recent received character from the active input.
// - with fifos off a new byte overwrites an unread one and raises overrun.
// - with fifos on a read returns and pops the head of the receive fifo.
// - a byte arriving at a full receive fifo is dropped, contents kept, overrun raised.
// - a written byte goes out on the serial or infrared transmit path.
// - with fifos off one write clears the transmit holding empty flag.
// - with fifos off a further write before the flag sets again replaces the byte.
// - with fifos on the transmit fifo takes a depth of bytes, 16 by default, before full.
// - a write to a full transmit fifo is discarded with no change to the fifo.
// - reserved bits 15:8 and the data byte reset to zero.
package usdp_pkg;
    localparam logic [31:0] USDP_SHADOW_BASE    = 32'h50001048;
    localparam logic [31:0] USDP_SHADOW_6       = 32'h50001048;
    localparam logic [31:0] USDP_SHADOW_7       = 32'h5000104C;
    localparam logic [31:0] USDP_SHADOW_SPAN    = 32'h00000040;
    localparam logic [31:0] USDP_CTRL_OFS       = 32'h00000100;
    localparam logic [31:0] USDP_STAT_OFS       = 32'h00000104;
    localparam logic [31:0] USDP_IRQ_OFS        = 32'h00000108;
    localparam logic [31:0] USDP_MASK_OFS       = 32'h0000010C;
    localparam logic [31:0] USDP_ADDR_MASK      = 32'hFFFFF000;
    localparam logic [31:0] USDP_PAGE           = 32'h50001000;
    localparam int          USDP_CTRL_FIFO_EN   = 0;
    localparam int          USDP_CTRL_IR_MODE   = 1;
    localparam int          USDP_STAT_DVALID    = 0;
    localparam int          USDP_STAT_OVERRUN   = 1;
    localparam int          USDP_STAT_TX_EMPTY  = 5;
    localparam int          USDP_STAT_TX_FULL   = 6;
    localparam int          USDP_IRQ_OVERRUN    = 0;
    localparam int          USDP_IRQ_RX         = 1;
    localparam int          USDP_IRQ_TX_EMPTY   = 2;
    localparam logic [7:0]  USDP_DATA_RESET     = 8'h00;
    localparam logic [15:0] USDP_WORD_RESET     = 16'h0000;
    localparam int          USDP_FIFO_DEPTH     = 16;
    localparam logic [1:0]  USDP_HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]  USDP_HTRANS_SEQ     = 2'h3;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } usdp_byte_t;

    typedef struct packed {
        logic       fifo_en;
        logic       ir_mode;
    } usdp_ctrl_t;
endpackage : usdp_pkg

//--- core/usdp_port.sv
// Local design decision: the AHB-Lite register port.
module usdp_port
    import usdp_pkg::*;
#(
    parameter int FIFO_DEPTH = USDP_FIFO_DEPTH
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rx_strobe,
    input  wire logic [7:0]  rx_byte,
    input  wire logic [7:0]  ir_rx_byte,
    output logic             tx_valid,
    output logic      [7:0]  tx_byte,
    input  wire logic        tx_take,
    output logic             tx_serial,
    output logic             tx_ir_n,
    output logic             irq
);
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("usdp_port fifo depth must be at least 2");
        end
    end

    // address phase capture
    logic        dp_valid_r;
    logic        dp_valid_nxt;
    logic        dp_write_r;
    logic        dp_write_nxt;
    logic [31:0] dp_addr_r;
    logic [31:0] dp_addr_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    usdp_ctrl_t  ctrl_r;
    usdp_ctrl_t  ctrl_nxt;
    logic [2:0]  ists_r;
    logic [2:0]  ists_nxt;
    logic [2:0]  imask_r;
    logic [2:0]  imask_nxt;
    logic        ovr_r;
    logic        ovr_nxt;
    logic        tx_wait_r;
    logic        tx_wait_nxt;

    function automatic logic is_shadow(input logic [31:0] a);
        is_shadow = (a >= USDP_SHADOW_BASE) &&
                    (a < USDP_SHADOW_BASE + USDP_SHADOW_SPAN);
    endfunction : is_shadow

    function automatic logic is_reg(input logic [31:0] a,
                                    input logic [31:0] ofs);
        is_reg = (a == (USDP_PAGE | ofs));
    endfunction : is_reg

    logic addr_ok;
    logic acc;
    logic wr_data;
    logic rd_data;
    logic wr_ctrl;
    logic wr_ists;
    logic wr_mask;

    assign addr_ok = (hsize == 3'h2) && (haddr[1:0] == 2'h0);
    assign acc     = hsel && hready && htrans[1] && addr_ok;
    assign wr_data = dp_valid_r && dp_write_r && is_shadow(dp_addr_r);
    assign wr_ctrl = dp_valid_r && dp_write_r
                     && is_reg(dp_addr_r, USDP_CTRL_OFS);
    assign wr_ists = dp_valid_r && dp_write_r
                     && is_reg(dp_addr_r, USDP_IRQ_OFS);
    assign wr_mask = dp_valid_r && dp_write_r
                     && is_reg(dp_addr_r, USDP_MASK_OFS);
    assign rd_data = acc && !hwrite && is_shadow(haddr);

    // receive side: hold register when fifos off, fifo when on
    logic       rx_push;
    logic [7:0] rx_in;
    logic [7:0] rxf_head;
    logic       rxf_empty;
    logic       rxf_full;
    usdp_byte_t rx_slot;
    logic       rx_valid;
    logic [7:0] rx_head;

    assign rx_in    = ctrl_r.ir_mode ? ir_rx_byte : rx_byte;
    assign rx_push  = rx_strobe && ctrl_r.fifo_en;
    assign rx_valid = ctrl_r.fifo_en ? !rxf_empty : rx_slot.valid;
    assign rx_head  = ctrl_r.fifo_en ? rxf_head : rx_slot.data;

    usdp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .flush     (!ctrl_r.fifo_en),
        .push      (rx_push),
        .push_data (rx_in),
        .pop       (rd_data && ctrl_r.fifo_en),
        .head      (rxf_head),
        .empty     (rxf_empty),
        .full      (rxf_full)
    );

    usdp_hold u_rx_hold (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .load      (rx_strobe && !ctrl_r.fifo_en),
        .load_data (rx_in),
        .take      (rd_data && !ctrl_r.fifo_en),
        .slot      (rx_slot)
    );

    // transmit side
    logic       txf_empty;
    logic       txf_full;
    logic [7:0] txf_head;
    usdp_byte_t tx_slot;
    logic       tx_empty_flag;

    usdp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .flush     (!ctrl_r.fifo_en),
        .push      (wr_data && ctrl_r.fifo_en),
        .push_data (hwdata[7:0]),
        .pop       (tx_take && ctrl_r.fifo_en),
        .head      (txf_head),
        .empty     (txf_empty),
        .full      (txf_full)
    );

    usdp_hold u_tx_hold (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .load      (wr_data && !ctrl_r.fifo_en),
        .load_data (hwdata[7:0]),
        .take      (tx_take && !ctrl_r.fifo_en),
        .slot      (tx_slot)
    );

    assign tx_empty_flag = ctrl_r.fifo_en ? txf_empty : !tx_slot.valid;
    // byte to serial or infrared path
    assign tx_valid  = ctrl_r.fifo_en ? !txf_empty : tx_slot.valid;
    assign tx_byte   = ctrl_r.fifo_en ? txf_head : tx_slot.data;
    // idle high per mode, else bit 0 of the pending byte on the active path (inverted for infrared)
    assign tx_serial = ctrl_r.ir_mode || !tx_valid ? 1'b1 : tx_byte[0];
    assign tx_ir_n   = !ctrl_r.ir_mode || !tx_valid ? 1'b1 : !tx_byte[0];

    logic ovr_evt;
    assign ovr_evt = rx_strobe &&
                     (ctrl_r.fifo_en ? rxf_full : rx_slot.valid);

    logic [2:0] ev;
    // empty flag rising: tx_wait_r resets low, so the flag that stands
    // after reset gives no false event
    assign ev = {tx_empty_flag && tx_wait_r, rx_strobe, ovr_evt};

    // address phase is kept for its data phase
    always_comb begin
        dp_valid_nxt = acc;
        dp_write_nxt = acc && hwrite;
        dp_addr_nxt  = haddr;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r  <= 32'h00000000;
        end else begin
            dp_valid_r <= dp_valid_nxt;
            dp_write_r <= dp_write_nxt;
            dp_addr_r  <= dp_addr_nxt;
        end
    end

    // read data stands one cycle, then falls back to zero
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (acc && !hwrite) begin
            if (is_shadow(haddr)) begin
                rdata_nxt = {24'h000000, rx_head};
            end else if (is_reg(haddr, USDP_CTRL_OFS)) begin
                rdata_nxt = {30'h00000000, ctrl_r.ir_mode, ctrl_r.fifo_en};
            end else if (is_reg(haddr, USDP_STAT_OFS)) begin
                rdata_nxt = 32'h00000000;
                rdata_nxt[USDP_STAT_DVALID]   = rx_valid;
                rdata_nxt[USDP_STAT_OVERRUN]  = ovr_r;
                rdata_nxt[USDP_STAT_TX_EMPTY] = tx_empty_flag;
                rdata_nxt[USDP_STAT_TX_FULL]  = ctrl_r.fifo_en && txf_full;
            end else if (is_reg(haddr, USDP_IRQ_OFS)) begin
                rdata_nxt = {29'h00000000, ists_r};
            end else if (is_reg(haddr, USDP_MASK_OFS)) begin
                rdata_nxt = {29'h00000000, imask_r};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    always_comb begin
        ctrl_nxt  = ctrl_r;
        imask_nxt = imask_r;
        if (wr_ctrl) begin
            ctrl_nxt.fifo_en = hwdata[USDP_CTRL_FIFO_EN];
            ctrl_nxt.ir_mode = hwdata[USDP_CTRL_IR_MODE];
        end
        if (wr_mask) begin
            imask_nxt = hwdata[2:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r  <= '{fifo_en: 1'b0, ir_mode: 1'b0};
            imask_r <= 3'h0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            imask_r <= imask_nxt;
        end
    end

    // overrun stays until status is read; new event wins
    always_comb begin
        ovr_nxt = ovr_r;
        if (acc && !hwrite && is_reg(haddr, USDP_STAT_OFS)) begin
            ovr_nxt = 1'b0;
        end
        if (ovr_evt) begin
            ovr_nxt = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovr_r <= 1'b0;
        end else begin
            ovr_r <= ovr_nxt;
        end
    end

    // sticky status: an event in the cycle of its clear wins
    always_comb begin
        tx_wait_nxt = !tx_empty_flag;
        ists_nxt    = ists_r;
        if (wr_ists) begin
            ists_nxt = ists_r & ~hwdata[2:0];
        end
        ists_nxt = ists_nxt | ev;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ists_r    <= 3'h0;
            tx_wait_r <= 1'b0;
        end else begin
            ists_r    <= ists_nxt;
            tx_wait_r <= tx_wait_nxt;
        end
    end

    assign hrdata    = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(ists_r & imask_r);
endmodule : usdp_port

//--- test/usdp_line_model.sv
module usdp_line_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       stall,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    output logic            tx_take,
    output logic            rx_strobe,
    output logic      [7:0] rx_byte,
    output logic      [7:0] ir_rx_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$];
    int         wait_n;
    initial begin
        rx_strobe = 1'b0;
        rx_byte = 8'h00;
        ir_rx_byte = 8'hFF;
    end
    // one strobe per character, never back to back
    task automatic send(input logic [7:0] b);
        @(posedge hclk);
        rx_strobe <= 1'b1;
        rx_byte <= b;
        ir_rx_byte <= ~b;
        @(posedge hclk);
        rx_strobe <= 1'b0;
        rx_byte <= ~b;
        ir_rx_byte <= b;
    endtask : send
    // the shifter takes a byte a few cycles after it is pending
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_take <= 1'b0;
            wait_n <= 0;
        end else begin
            tx_take <= 1'b0;
            if (tx_valid && !tx_take && !stall) begin
                wait_n <= wait_n + 1;
                if (wait_n == 3) begin
                    tx_take <= 1'b1;
                    got.push_back(tx_byte);
                    wait_n <= 0;
                end
            end
        end
    end
endmodule : usdp_line_model

//--- test/usdp_port_asserts.sv
module usdp_port_asserts
    import usdp_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_byte,
    input wire logic        tx_take,
    input wire logic        tx_serial,
    input wire logic        tx_ir_n,
    input wire logic        irq
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic take_ok;
    logic wr_sh;
    logic wr_d;
    assign take_ok = hsel && hready && htrans[1] && hsize == 3'h2
                     && haddr[1:0] == 2'h0;
    assign wr_sh = take_ok && hwrite && haddr >= USDP_SHADOW_BASE
                   && haddr < USDP_SHADOW_BASE + USDP_SHADOW_SPAN;
    // a shadow write lands at the end of its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            wr_d <= 1'b0;
        else
            wr_d <= wr_sh;
    end
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_upper_zero: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_rdata_cause: assert property
        (hrdata != 32'h0 |-> $past(take_ok && !hwrite))
        else $error("read data without a read");
    chk_unmapped_zero: assert property
        (take_ok && haddr[31:12] != USDP_PAGE[31:12] |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_reset_state: assert property
        ($rose(hresetn) |-> hrdata == 32'h0 && !irq && !tx_valid)
        else $error("outputs not cleared by reset");
    chk_tx_after_wr: assert property
        (wr_sh ##1 !tx_take |=> tx_valid)
        else $error("written byte not pending");
    chk_line_idle: assert property
        (!tx_valid [*2] |-> tx_serial && tx_ir_n)
        else $error("line not idle high");
    chk_tx_held: assert property
        (tx_valid && !tx_take && !wr_d |=> !tx_valid || $stable(tx_byte))
        else $error("pending byte changed without a write");
    cover property (wr_sh);
    cover property (take_ok && !hwrite ##1 hrdata != 32'h0);
    cover property ($rose(irq));
endmodule : usdp_port_asserts

bind usdp_port usdp_port_asserts usdp_port_asserts_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_take(tx_take),
    .tx_serial(tx_serial), .tx_ir_n(tx_ir_n), .irq(irq)
);

//--- test/usdp_port_tb.sv
module usdp_port_tb;
    import usdp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DEPTH = 4;
    localparam logic [31:0] SH = USDP_SHADOW_BASE;
    localparam logic [31:0] CTRL = USDP_PAGE + USDP_CTRL_OFS;
    localparam logic [31:0] STAT = USDP_PAGE + USDP_STAT_OFS;
    localparam logic [31:0] IST = USDP_PAGE + USDP_IRQ_OFS;
    localparam logic [31:0] MSK = USDP_PAGE + USDP_MASK_OFS;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, stall = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, rx_strobe, tx_valid, tx_take, tx_serial;
    logic tx_ir_n, irq;
    logic [7:0] rx_byte, ir_rx_byte, tx_byte;
    int err_count = 0, tests_run = 0;
    always #25 hclk = ~hclk;
    usdp_port #(.FIFO_DEPTH(DEPTH)) usdp_port_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rx_strobe(rx_strobe), .rx_byte(rx_byte),
        .ir_rx_byte(ir_rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_take(tx_take), .tx_serial(tx_serial), .tx_ir_n(tx_ir_n),
        .irq(irq));
    usdp_line_model usdp_line_model_inst (
        .hclk(hclk), .hresetn(hresetn), .stall(stall), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_take(tx_take), .rx_strobe(rx_strobe),
        .rx_byte(rx_byte), .ir_rx_byte(ir_rx_byte));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic xfer(logic [31:0] a, logic w, logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= USDP_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic wr(logic [31:0] a, logic [31:0] d);
        logic [31:0] rd;
        xfer(a, 1'b1, d, rd);
    endtask : wr
    task automatic rdc(string what, logic [31:0] a, logic [31:0] m,
                       logic [31:0] exp);
        logic [31:0] rd;
        xfer(a, 1'b0, 32'h0, rd);
        check(what, rd & m, exp);
    endtask : rdc
    task automatic send(logic [7:0] b);
        usdp_line_model_inst.send(b);
    endtask : send
    task automatic wait_tx(int n);
        for (int i = 0; i < 60 && usdp_line_model_inst.got.size() < n; i++)
            @(posedge hclk);
    endtask : wait_tx
    task automatic test_done;
        $display("tests_run %0d err_count %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    initial begin
        #1000000;
        err_count++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("shadow6", USDP_SHADOW_6, 32'hFFFFFFFF, 32'h0);
        rdc("shadow7", USDP_SHADOW_7, 32'hFFFFFFFF, 32'h0);
        rdc("stat", STAT, 32'h23, 32'h20);
        $display("test reset done");
        send(8'hA5);
        rdc("rx valid", STAT, 32'h23, 32'h21);
        rdc("rx byte", USDP_SHADOW_6, 32'hFFFFFFFF, 32'hA5);
        send(8'h11);
        send(8'h22);
        rdc("overrun", STAT, 32'h23, 32'h23);
        rdc("overwrite", USDP_SHADOW_7, 32'hFFFFFFFF, 32'h22);
        wr(CTRL, 32'h2);
        send(8'h3C);
        rdc("ir byte", SH + 32'h3C, 32'hFFFFFFFF, 32'hC3);
        wr(CTRL, 32'h0);
        $display("test rx done");
        rdc("tx ready", STAT, 32'h20, 32'h20);
        stall <= 1'b1;
        wr(USDP_SHADOW_6, 32'hABCD12C1);
        rdc("tx empty", STAT, 32'h20, 32'h0);
        wr(USDP_SHADOW_7, 32'h0000FF5A);
        @(posedge hclk);
        check("tx line", {30'h0, tx_serial, tx_ir_n}, 32'h1);
        stall <= 1'b0;
        wait_tx(1);
        repeat (20) @(posedge hclk);
        check("tx count", usdp_line_model_inst.got.size(), 1);
        check("tx byte", usdp_line_model_inst.got[0], 32'h5A);
        rdc("tx empty", STAT, 32'h20, 32'h20);
        $display("test tx done");
        wr(CTRL, 32'h1);
        for (int i = 0; i <= DEPTH; i++)
            send(8'h30 + i[7:0]);
        rdc("fifo overrun", STAT, 32'h03, 32'h03);
        for (int i = 0; i < DEPTH; i++)
            rdc("rx head", SH + 4 * i, 32'hFFFFFFFF, 32'h30 + i);
        rdc("fifo empty", STAT, 32'h01, 32'h0);
        usdp_line_model_inst.got.delete();
        stall <= 1'b1;
        for (int i = 0; i <= DEPTH; i++)
            wr(SH + 4 * i, 32'h40 + i);
        rdc("tx full", STAT, 32'h60, 32'h40);
        stall <= 1'b0;
        wait_tx(DEPTH);
        repeat (20) @(posedge hclk);
        check("tx depth", usdp_line_model_inst.got.size(), DEPTH);
        for (int i = 0; i < DEPTH; i++)
            check("txf", usdp_line_model_inst.got[i], 32'h40 + i);
        $display("test fifo done");
        wr(CTRL, 32'h0);
        rdc("tx empty event", IST, 32'h4, 32'h4);
        wr(IST, 32'h7);
        rdc("tx event edge", IST, 32'h4, 32'h0);
        wr(MSK, 32'h0);
        send(8'h01);
        send(8'h02);
        repeat (2) @(posedge hclk);
        check("irq masked", {31'h0, irq}, 32'h0);
        rdc("rx events", IST, 32'h3, 32'h3);
        wr(MSK, 32'h1);
        repeat (2) @(posedge hclk);
        check("irq set", {31'h0, irq}, 32'h1);
        wr(IST, 32'h1);
        repeat (2) @(posedge hclk);
        check("irq clear", {31'h0, irq}, 32'h0);
        rdc("unmapped", USDP_PAGE + 32'h200, 32'hFFFFFFFF, 32'h0);
        $display("test irq done");
        test_done();
    end
endmodule : usdp_port_tb
